// file: core/evp_vector_ctrl.v
// exception vector priority decoder with request test banks and ahb-lite registers
//
// Decided for this implementation: the AHB-Lite slave port.
`default_nettype none
`include "evp_defines.vh"

module evp_vector_ctrl #(
    parameter NUM_I = 122
) (
    // clock and reset
    input wire mclk,
    input wire rst_b,
    // ahb-lite slave
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg hreadyout,
    output reg [31:0] hrdata,
    output reg hresp,
    // exception requests
    input wire [NUM_I-1:0] irq_req,
    input wire high_priority_ext_pin,
    input wire software_exception,
    input wire trap_req,
    input wire sys_reset_req,
    input wire clock_monitor_reset,
    input wire watchdog_reset,
    // core status
    input wire i_mask,
    input wire x_mask,
    input wire block_i,
    input wire block_x,
    input wire special_mode,
    input wire vec_fetch,
    // to core and system
    output reg [15:0] vec_addr,
    output reg int_pending,
    output reg wakeup
);

localparam integer BASE_V = `EVP_I_MAX - NUM_I;
localparam [6:0] BASE_V7 = BASE_V[6:0];
// reset words held at full width so fields can be sliced out
localparam [7:0] TCTL_RST = `EVP_TCTL_RST;
localparam [7:0] PSEL_RST = `EVP_PSEL_RST;

// reset release
reg rst_meta_b_ff;
reg rst_sync_b_ff;
wire srst_b;

// register state
reg wte_ff;
reg [3:0] bank_ff;
reg [6:0] psel_ff;

// bus pipeline
reg wr_pend_ff;
reg rd_pend_ff;
reg [7:0] idx_ff;

// decoder state
reg fetch_d_ff;
reg seen_ff;
reg [7:0] last_lb_ff;

// request vectors by slot (low byte / 2)
wire [`EVP_NSLOT-1:0] live_flat;
wire [`EVP_NSLOT-1:0] impl_flat;
wire [`EVP_NSLOT-1:0] src_flat;
wire [`EVP_NSLOT-1:0] ival_flat;
wire [`EVP_NSLOT-1:0] force_flat;
wire [7:0] force_rd;

// decode
reg [6:0] best_v;
reg [7:0] sel_lb;
reg sel_valid;
integer v;
wire any_i;
wire x_src;
wire x_valid;
wire [6:0] prom_v;
wire prom_hit;

// bus decode
wire take;
wire wr_ok;
wire tctl_wr;
wire wte_wr_ok;
wire fbank_wr;
wire psel_wr;
wire snap;
wire [7:0] bank_live;
wire [7:0] bank_impl;
wire [7:0] bank_rd;

assign srst_b = rst_sync_b_ff;

always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
        rst_meta_b_ff <= 1'b0;
        rst_sync_b_ff <= 1'b0;
    end else begin
        rst_meta_b_ff <= 1'b1;
        rst_sync_b_ff <= rst_meta_b_ff;
    end
end

// per-slot sources; slot 121 is the maskable pin, 122 the high-priority pin
genvar g;
generate
    for (g = 0; g < `EVP_NSLOT; g = g + 1) begin : g_slot
        if (g >= BASE_V && g <= `EVP_V_IRQ) begin : g_i
            assign live_flat[g] = irq_req[g - BASE_V];
            assign impl_flat[g] = 1'b1;
            assign ival_flat[g] = src_flat[g] & ~i_mask & ~block_i;
        end else if (g == `EVP_V_HIGH_PRIORITY_EXT_PIN) begin : g_x
            assign live_flat[g] = high_priority_ext_pin;
            assign impl_flat[g] = 1'b1;
            assign ival_flat[g] = 1'b0;
        end else begin : g_none
            assign live_flat[g] = 1'b0;
            assign impl_flat[g] = 1'b0;
            assign ival_flat[g] = 1'b0;
        end
    end
endgenerate

// forced values replace the live inputs while the enable is set
assign src_flat = wte_ff ? (force_flat & impl_flat) : live_flat;

assign any_i = |ival_flat;
assign x_src = src_flat[`EVP_V_HIGH_PRIORITY_EXT_PIN];
assign x_valid = x_src & ~x_mask & ~block_x;

// promoted source: out-of-range selections fall back to the maskable pin
assign prom_v = (psel_ff >= BASE_V7 && psel_ff <= `EVP_V_IRQ) ? psel_ff : `EVP_V_IRQ;
assign prom_hit = ival_flat[prom_v];

// highest slot wins among I sources
always @* begin
    best_v = 7'd0;
    for (v = 0; v < `EVP_NSLOT; v = v + 1) begin
        if (ival_flat[v]) begin
            best_v = v[6:0];
        end
    end
end

always @* begin
    sel_valid = 1'b1;
    if (sys_reset_req) begin
        sel_lb = `EVP_LB_SYS;
    end else if (clock_monitor_reset) begin
        sel_lb = `EVP_LB_CMR;
    end else if (watchdog_reset) begin
        sel_lb = `EVP_LB_WDOG;
    end else if (trap_req) begin
        sel_lb = `EVP_LB_TRAP;
    end else if (software_exception) begin
        sel_lb = `EVP_LB_SWI;
    end else if (x_valid) begin
        sel_lb = {`EVP_V_HIGH_PRIORITY_EXT_PIN, 1'b0};
    end else if (prom_hit) begin
        sel_lb = {prom_v, 1'b0};
    end else if (any_i) begin
        sel_lb = {best_v, 1'b0};
    end else begin
        sel_lb = `EVP_LB_SWI;
        sel_valid = 1'b0;
    end
end

// vector latched at the start of the fetch and held while it lasts
always @(posedge mclk or negedge srst_b) begin
    if (!srst_b) begin
        fetch_d_ff <= 1'b0;
        seen_ff <= 1'b0;
        last_lb_ff <= `EVP_LB_SWI;
        vec_addr <= `EVP_VEC_RST;
    end else begin
        fetch_d_ff <= vec_fetch;
        if (sel_valid) begin
            seen_ff <= 1'b1;
            last_lb_ff <= sel_lb;
        end
        if (vec_fetch && !fetch_d_ff) begin
            if (sel_valid) begin
                vec_addr <= {`EVP_VEC_HI, sel_lb};
            end else if (seen_ff) begin
                vec_addr <= {`EVP_VEC_HI, last_lb_ff};
            end else begin
                vec_addr <= {`EVP_VEC_HI, `EVP_LB_SWI};
            end
        end
    end
end

// pending and wake flags
always @(posedge mclk or negedge srst_b) begin
    if (!srst_b) begin
        int_pending <= 1'b0;
        wakeup <= 1'b0;
    end else begin
        int_pending <= any_i | x_valid;
        wakeup <= any_i | x_valid | x_src;
    end
end

// ahb-lite: writes zero-wait, reads one wait state
assign take = hsel & htrans[1] & hready;
assign wr_ok = wr_pend_ff & hready;
assign tctl_wr = wr_ok && idx_ff == `EVP_IDX_TCTL;
assign fbank_wr = wr_ok && idx_ff == `EVP_IDX_FBANK;
assign psel_wr = wr_ok && idx_ff == `EVP_IDX_PSEL;
assign wte_wr_ok = tctl_wr & special_mode & i_mask & x_mask;

// setting the enable copies live requests into the forced store
assign snap = wte_wr_ok & hwdata[`EVP_TCTL_WTE] & ~wte_ff;

always @(posedge mclk or negedge srst_b) begin
    if (!srst_b) begin
        wr_pend_ff <= 1'b0;
        rd_pend_ff <= 1'b0;
        idx_ff <= 8'h00;
        hreadyout <= 1'b1;
        hresp <= `EVP_HRESP_OKAY;
    end else begin
        hresp <= `EVP_HRESP_OKAY;
        if (rd_pend_ff) begin
            rd_pend_ff <= 1'b0;
            hreadyout <= 1'b1;
        end else if (hready) begin
            wr_pend_ff <= take & hwrite & (hsize == `EVP_HSIZE_WORD);
            rd_pend_ff <= take & ~hwrite;
            hreadyout <= ~(take & ~hwrite);
            if (take) begin
                idx_ff <= haddr[9:2];
            end
        end
    end
end

// test_control and promoted_source_select
always @(posedge mclk or negedge srst_b) begin
    if (!srst_b) begin
        wte_ff <= TCTL_RST[`EVP_TCTL_WTE];
        bank_ff <= TCTL_RST[`EVP_TCTL_BANK_HI:`EVP_TCTL_BANK_LO];
        psel_ff <= PSEL_RST[7:1];
    end else begin
        if (tctl_wr) begin
            bank_ff <= hwdata[`EVP_TCTL_BANK_HI:`EVP_TCTL_BANK_LO];
        end
        if (wte_wr_ok) begin
            wte_ff <= hwdata[`EVP_TCTL_WTE];
        end
        if (psel_wr && i_mask) begin
            psel_ff <= hwdata[7:1];
        end
    end
end

// bank view: bit j of bank b is slot b*8+j
assign bank_live = live_flat[bank_ff*8 +: 8];
assign bank_impl = impl_flat[bank_ff*8 +: 8];
assign bank_rd = special_mode ? ((wte_ff ? force_rd : bank_live) & bank_impl) : 8'h00;

evp_force_bank #(
    .NBANK(`EVP_NBANK)
) u_force (
    .mclk(mclk),
    .rst_b(srst_b),
    .wr_en(fbank_wr & special_mode & wte_ff & i_mask),
    .wr_bank(bank_ff),
    .wr_data(hwdata[7:0] & bank_impl),
    .snap_en(snap),
    .snap_data(live_flat),
    .rd_bank(bank_ff),
    .rd_ff(force_rd),
    .flat(force_flat)
);

// read data taken in the wait cycle of a read
always @(posedge mclk or negedge srst_b) begin
    if (!srst_b) begin
        hrdata <= 32'h00000000;
    end else if (rd_pend_ff) begin
        case (idx_ff)
            `EVP_IDX_TCTL: begin
                hrdata <= {27'h0000000, wte_ff, bank_ff};
            end
            `EVP_IDX_FBANK: begin
                hrdata <= {24'h000000, bank_rd};
            end
            `EVP_IDX_PSEL: begin
                hrdata <= {24'h000000, psel_ff, 1'b0};
            end
            default: begin
                hrdata <= 32'h00000000;
            end
        endcase
    end
end

endmodule // evp_vector_ctrl

`default_nettype wire

// file: core/evp_defines.vh
// register indices, field positions, reset values and vector codes of the exception vector block
`ifndef EVP_DEFINES_VH
`define EVP_DEFINES_VH

// register indices; byte address is four times the index
`define EVP_IDX_TCTL 8'h15
`define EVP_IDX_FBANK 8'h16
`define EVP_IDX_PSEL 8'h1f

// test_control fields
`define EVP_TCTL_WTE 4
`define EVP_TCTL_BANK_HI 3
`define EVP_TCTL_BANK_LO 0

// reset values
`define EVP_TCTL_RST 8'h00
`define EVP_FBANK_RST 8'h00
`define EVP_PSEL_RST 8'hf2
`define EVP_VEC_RST 16'hfffe

// vector codes: high byte and low bytes
`define EVP_VEC_HI 8'hff
`define EVP_LB_SYS 8'hfe
`define EVP_LB_CMR 8'hfc
`define EVP_LB_WDOG 8'hfa
`define EVP_LB_TRAP 8'hf8
`define EVP_LB_SWI 8'hf6

// vector slots (low byte / 2)
`define EVP_I_MAX 122
`define EVP_V_IRQ 7'd121
`define EVP_V_HIGH_PRIORITY_EXT_PIN 7'd122
`define EVP_NBANK 16
`define EVP_NSLOT 128

// ahb-lite codes
`define EVP_HSIZE_WORD 3'b010
`define EVP_HRESP_OKAY 1'b0

`endif

// file: core/evp_force_bank.v
// bank-organised store of forced request bits with registered bank read
`default_nettype none
`include "evp_defines.vh"

module evp_force_bank #(
    parameter NBANK = 16
) (
    // clock and reset
    input wire mclk,
    input wire rst_b,
    // bank write
    input wire wr_en,
    input wire [3:0] wr_bank,
    input wire [7:0] wr_data,
    // whole-store load
    input wire snap_en,
    input wire [NBANK*8-1:0] snap_data,
    // read side
    input wire [3:0] rd_bank,
    output reg [7:0] rd_ff,
    output wire [NBANK*8-1:0] flat
);

wire [NBANK*8-1:0] mem_flat;

assign flat = mem_flat;

// one byte register per bank; a bank write of the same edge overrides the snapshot
genvar b;
generate
    for (b = 0; b < NBANK; b = b + 1) begin : g_bank
        reg [7:0] cell_ff;
        assign mem_flat[b*8 +: 8] = cell_ff;
        always @(posedge mclk or negedge rst_b) begin
            if (!rst_b) begin
                cell_ff <= `EVP_FBANK_RST;
            end else if (wr_en && wr_bank == b) begin
                cell_ff <= wr_data;
            end else if (snap_en) begin
                cell_ff <= snap_data[b*8 +: 8];
            end
        end
    end
endgenerate

always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
        rd_ff <= 8'h00;
    end else begin
        rd_ff <= mem_flat[rd_bank*8 +: 8];
    end
end

endmodule // evp_force_bank

`default_nettype wire

// file: testbench/evp_vector_ctrl_properties.sv
// port-level checks for the exception vector block
`default_nettype none
module evp_vector_ctrl_properties #(
    parameter int NUM_I = 122
) (
    // clock, reset and bus
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic hsel,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic [1:0] htrans,
    // requests and core status
    input wire logic [NUM_I-1:0] irq_req,
    input wire logic high_priority_ext_pin,
    input wire logic sys_reset_req,
    input wire logic i_mask,
    input wire logic x_mask,
    input wire logic block_i,
    input wire logic block_x,
    input wire logic special_mode,
    input wire logic vec_fetch,
    // results
    input wire logic [15:0] vec_addr,
    input wire logic int_pending,
    input wire logic wakeup
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [2:0] up_ff;
    logic v_i;
    logic v_x;
    // follows the internal two-flop release plus one settling cycle
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            up_ff <= 3'h0;
        end else begin
            up_ff <= {up_ff[1:0], 1'b1};
        end
    end
    assign v_i = |irq_req && !i_mask && !block_i;
    assign v_x = high_priority_ext_pin && !x_mask && !block_x;
    default clocking @(posedge mclk); endclocking
    default disable iff (!up_ff[2]);
    sequence fetch_start;
        $rose(vec_fetch) && !special_mode;
    endsequence
    chk_pend_set: assert property (!special_mode && (v_i || v_x) |=> int_pending)
        else $error("pending flag missing");
    chk_pend_clr: assert property (!special_mode && !v_i && !v_x |=> !int_pending)
        else $error("pending flag without request");
    chk_block_both: assert property (!special_mode && block_i && block_x |=> !int_pending)
        else $error("blocked request still pending");
    chk_wake_pin: assert property (!special_mode && high_priority_ext_pin |=> wakeup)
        else $error("no wakeup for pin");
    chk_wake_irq: assert property (!special_mode && v_i |=> wakeup)
        else $error("no wakeup for request");
    chk_vec_hold: assert property (vec_fetch [*3] |=> $stable(vec_addr))
        else $error("vector moved during fetch");
    chk_vec_sys: assert property (fetch_start ##0 sys_reset_req |-> ##[1:2] vec_addr == 16'hfffe)
        else $error("reset vector not given");
    chk_read_wait: assert property (hsel && htrans[1] && !hwrite && hready |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    cover property (fetch_start);
    cover property (v_x);
    cover property (hsel && htrans[1] && !hwrite && hready);
endmodule // evp_vector_ctrl_properties
bind evp_vector_ctrl evp_vector_ctrl_properties #(.NUM_I(NUM_I)) u_props (.mclk(mclk), .rst_b(rst_b),
    .hsel(hsel), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .htrans(htrans), .irq_req(irq_req),
    .high_priority_ext_pin(high_priority_ext_pin), .sys_reset_req(sys_reset_req), .i_mask(i_mask),
    .x_mask(x_mask), .block_i(block_i), .block_x(block_x), .special_mode(special_mode),
    .vec_fetch(vec_fetch), .vec_addr(vec_addr), .int_pending(int_pending), .wakeup(wakeup));
`default_nettype wire

// file: testbench/evp_core_model.sv
// processor-side model performing exception vector fetches
`default_nettype none
module evp_core_model (
    // clock
    input wire logic mclk,
    // vector fetch
    input wire logic [15:0] vec_addr,
    output var logic vec_fetch
);
    timeunit 1ns;
    timeprecision 100ps;
    initial vec_fetch = 1'b0;
    // hold of at least 4 edges; larger values model a slow core
    task automatic fetch(input int hold, output logic [15:0] vec);
        @(posedge mclk);
        vec_fetch <= 1'b1;
        repeat (hold) @(posedge mclk);
        vec = vec_addr;
        vec_fetch <= 1'b0;
        @(posedge mclk);
    endtask
endmodule // evp_core_model
`default_nettype wire

// file: testbench/exception_vector_priority_bench.sv
// self-checking bench for the exception vector block
`default_nettype none
`include "evp_defines.vh"
module exception_vector_priority_bench;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int NI = 114;
    logic mclk, rst_b, hsel, hwrite, hreadyout, hresp, vec_fetch, int_pending, wakeup;
    logic i_mask, x_mask, block_i, block_x, special;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [5:0] nm;
    logic [15:0] vec_addr, v;
    logic [31:0] haddr, hwdata, hrdata, rdv;
    logic [NI-1:0] irq_req;
    int err_count, n_checks;
    evp_vector_ctrl #(.NUM_I(NI)) DUT (.mclk(mclk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .irq_req(irq_req),
        .high_priority_ext_pin(nm[0]), .software_exception(nm[1]), .trap_req(nm[2]), .watchdog_reset(nm[3]),
        .clock_monitor_reset(nm[4]), .sys_reset_req(nm[5]), .i_mask(i_mask), .x_mask(x_mask),
        .block_i(block_i), .block_x(block_x), .special_mode(special), .vec_fetch(vec_fetch),
        .vec_addr(vec_addr), .int_pending(int_pending), .wakeup(wakeup));
    evp_core_model core (.mclk(mclk), .vec_addr(vec_addr), .vec_fetch(vec_fetch));
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    task automatic report_and_stop;
        if (err_count == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic tally(input logic bad, input string what);
        n_checks++;
        if (bad) begin
            err_count++;
            $display("MISMATCH %0t %s", $time, what);
        end
    endtask
    task automatic chk_reg(input logic [31:0] got, exp);
        tally(got !== exp, "register read");
    endtask
    task automatic chk_vec(input logic [15:0] got, exp);
        tally(got !== exp, "vector");
    endtask
    task automatic chk_bit(input logic got, exp);
        tally(got !== exp, "flag");
    endtask
    task automatic wait_rdy;
        int n;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 40);
        if (n >= 40) begin
            tally(1'b1, "bus timeout");
            report_and_stop();
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] idx, wd, output logic [31:0] rd);
        htrans <= 2'b10;
        hwrite <= wr;
        haddr <= {22'h0, idx, 2'b00};
        wait_rdy();
        htrans <= 2'b00;
        hwdata <= {24'h0, wd};
        wait_rdy();
        rd = hrdata;
    endtask
    task automatic wr(input logic [7:0] idx, d);
        bus(1'b1, idx, d, rdv);
    endtask
    task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
        bus(1'b0, idx, 8'h00, rdv);
        chk_reg(rdv, exp);
        chk_bit(hresp, `EVP_HRESP_OKAY);
    endtask
    task automatic drv(input logic [5:0] n, input logic [NI-1:0] ir, input logic [1:0] msk);
        @(posedge mclk);
        nm <= n;
        irq_req <= ir;
        {i_mask, x_mask} <= msk;
        repeat (2) @(posedge mclk);
    endtask
    task automatic fetch_chk(input int hold, input logic [15:0] exp);
        core.fetch(hold, v);
        chk_vec(v, exp);
    endtask
    initial begin
        {err_count, n_checks} = '0;
        {rst_b, hsel, hwrite, block_i, block_x, special, nm} = '0;
        {htrans, haddr, hwdata, irq_req} = '0;
        {i_mask, x_mask, hsize} = {2'b11, `EVP_HSIZE_WORD};
        repeat (16) @(posedge mclk);
        rst_b <= 1'b1;
        hsel <= 1'b1;
        repeat (4) @(posedge mclk);
        rd_chk(`EVP_IDX_TCTL, 32'h00);
        rd_chk(`EVP_IDX_PSEL, 32'hf2);
        rd_chk(`EVP_IDX_FBANK, 32'h00);
        rd_chk(8'h20, 32'h00);
        fetch_chk(4, 16'hfff6);
        for (int s = 0; s < 8; s++) begin
            drv(6'h3f >> s, {s < 7, 1'b1, 112'h0}, 2'b00);
            fetch_chk(4 + s % 2, 16'hfffe - 16'(2 * s));
        end
        chk_bit(int_pending, 1'b1);
        drv(6'h00, 114'h1, 2'b00);
        fetch_chk(4, 16'hff10);
        drv(6'h01, 114'h20, 2'b11);
        chk_bit(int_pending, 1'b0);
        chk_bit(wakeup, 1'b1);
        fetch_chk(4, 16'hff10);
        @(posedge mclk);
        {block_i, block_x} <= 2'b11;
        drv(6'h01, 114'h20, 2'b00);
        chk_bit(int_pending, 1'b0);
        @(posedge mclk);
        {block_i, block_x} <= 2'b00;
        drv(6'h00, 114'h20, 2'b00);
        chk_bit(wakeup, 1'b1);
        drv(6'h00, 114'h0, 2'b10);
        wr(`EVP_IDX_PSEL, 8'h10);
        rd_chk(`EVP_IDX_PSEL, 32'h10);
        drv(6'h00, 114'h0, 2'b00);
        wr(`EVP_IDX_PSEL, 8'h20);
        rd_chk(`EVP_IDX_PSEL, 32'h10);
        drv(6'h00, {2'b10, 112'h1}, 2'b00);
        fetch_chk(4, 16'hff10);
        drv(6'h00, {2'b10, 112'h1}, 2'b10);
        wr(`EVP_IDX_PSEL, 8'hfa);
        drv(6'h00, {2'b10, 112'h1}, 2'b00);
        fetch_chk(4, 16'hfff2);
        wr(`EVP_IDX_TCTL, 8'h1f);
        rd_chk(`EVP_IDX_TCTL, 32'h0f);
        rd_chk(`EVP_IDX_FBANK, 32'h00);
        @(posedge mclk);
        special <= 1'b1;
        drv(6'h00, {2'b10, 112'h1}, 2'b10);
        wr(`EVP_IDX_TCTL, 8'h1f);
        rd_chk(`EVP_IDX_TCTL, 32'h0f);
        rd_chk(`EVP_IDX_FBANK, 32'h02);
        drv(6'h00, {2'b10, 112'h1}, 2'b11);
        wr(`EVP_IDX_TCTL, 8'h1f);
        rd_chk(`EVP_IDX_TCTL, 32'h1f);
        drv(6'h00, 114'h0, 2'b11);
        rd_chk(`EVP_IDX_FBANK, 32'h02);
        wr(`EVP_IDX_FBANK, 8'hff);
        rd_chk(`EVP_IDX_FBANK, 32'h07);
        drv(6'h00, 114'h0, 2'b00);
        fetch_chk(4, 16'hfff4);
        drv(6'h00, 114'h0, 2'b11);
        wr(`EVP_IDX_TCTL, 8'h10);
        wr(`EVP_IDX_FBANK, 8'hff);
        rd_chk(`EVP_IDX_FBANK, 32'h00);
        wr(`EVP_IDX_TCTL, 8'h11);
        wr(`EVP_IDX_FBANK, 8'h81);
        rd_chk(`EVP_IDX_FBANK, 32'h81);
        drv(6'h00, 114'h0, 2'b01);
        wr(`EVP_IDX_FBANK, 8'h00);
        rd_chk(`EVP_IDX_FBANK, 32'h81);
        drv(6'h00, 114'h0, 2'b11);
        wr(`EVP_IDX_TCTL, 8'h01);
        @(posedge mclk);
        special <= 1'b0;
        report_and_stop();
    end
endmodule // exception_vector_priority_bench
`default_nettype wire
